// ### mrf_pkg.sv
// Constants, types and check function of the Modbus RTU master framer
package mrf_pkg;
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_EVEN = 2'h1;
  localparam logic [1:0] PAR_ODD = 2'h2;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'ha001;
  // Residue of the check run over a frame including its own check bytes
  localparam logic [15:0] CRC_GOOD = 16'h0000;
  localparam int DATA_BITS = 8;
  localparam int BITS_BASE = 10; // Start, data, stop
  localparam int GAP_END_HALF = 7; // 3.5 characters in half characters
  localparam int GAP_DROP_HALF = 3; // 1.5 characters in half characters
  localparam logic [7:0] ADDR_BCAST = 8'h00;
  localparam logic [7:0] ADDR_MAX = 8'hf7;
  localparam int FN_ERR_BIT = 7;
  localparam logic [3:0] MIN_FRAME = 4'h4;
  localparam logic [1:0] TAIL_DATA = 2'h0;
  localparam logic [1:0] TAIL_LO = 2'h1;
  localparam logic [1:0] TAIL_HI = 2'h2;

  typedef enum logic {TX_IDLE = 1'b0, TX_SEND = 1'b1} mrf_tx_t;
  typedef enum logic {RX_IDLE = 1'b0, RX_BUSY = 1'b1} mrf_rx_t;

  // One byte through the frame check, low bit first
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < DATA_BITS; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc_step
endpackage : mrf_pkg

// ### mrf_master.sv
// Modbus RTU master framer: sends request frames, frames and checks replies
// Functional notes
// - New frame only after 3.5 idle characters
// - Order: address, function, data, check word
// - Frame ends after 3.5 idle characters; the receiver closes a reply after 1.5
// - Master spaces its frames by 3.5 characters
// - All nodes share baud, data, parity settings
// - Parity selectable even, odd or none
// - Even parity: bit set on odd count
// - Odd parity: bit set on even count
// - Sixteen-bit check word protects every frame
// - Check register starts at all ones
// - Only the eight data bits are checked
// - Shift right, XOR a001 on carry, eight times
// - Check word low byte sent first
`timescale 1ns/1ps
`default_nettype none
module mrf_master #(
  parameter int CPB = 26042, // Clocks per bit, 9600 baud
  parameter int GW = 24
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [1:0] parity_mode_i,
  input wire logic [7:0] s_data_i,
  input wire logic s_last_i,
  input wire logic s_valid_i,
  output logic s_ready_o,
  output logic tx_o,
  output logic de_o,
  input wire logic rx_i,
  output logic [7:0] rx_data_o,
  output logic rx_valid_o,
  output logic rx_first_o,
  output logic frame_done_o,
  output logic frame_ok_o,
  output logic crc_err_o,
  output logic par_err_o,
  output logic addr_err_o,
  output logic exc_o,
  output logic tx_done_o
);
  localparam int CW = $clog2(CPB) + 1;
  localparam logic [CW-1:0] CPB_M1 = CW'(CPB - 1);
  localparam logic [CW-1:0] CPB_HALF = CW'(CPB / 2);

  typedef struct packed {
    mrf_pkg::mrf_tx_t tx_st;
    logic [1:0] tail;
    logic last;
    logic [9:0] tx_sh;
    logic [3:0] tx_cnt;
    logic [CW-1:0] tx_baud;
    logic [15:0] tx_crc;
    logic [7:0] tx_addr;
    logic tx_line;
    logic de;
    logic tx_done;
    logic [1:0][8:0] buf_d;
    logic buf_wp;
    logic buf_rp;
    logic [1:0] buf_n;
    logic rdy;
    logic [GW-1:0] idle;
    mrf_pkg::mrf_rx_t rx_st;
    logic [CW-1:0] rx_baud;
    logic [3:0] rx_k;
    logic [7:0] rx_sh;
    logic rx_pb;
    logic [15:0] rx_crc;
    logic [3:0] rx_cnt;
    logic rx_in;
    logic [7:0] rx_addr;
    logic [7:0] rx_fn;
    logic perr;
    logic [7:0] rx_data;
    logic rx_valid;
    logic rx_first;
    logic done;
    logic ok;
    logic crc_err;
    logic par_err;
    logic addr_err;
    logic exc;
  } mrf_st_t;

  localparam mrf_st_t ST_RST = '{tx_st: mrf_pkg::TX_IDLE, rx_st: mrf_pkg::RX_IDLE,
                                 tx_line: 1'b1, default: '0};

  mrf_st_t q;
  mrf_st_t n;
  logic par_on;
  logic [3:0] nb_m1;
  logic [GW-1:0] chr;
  logic [GW-1:0] t35;
  logic [GW-1:0] t15;
  logic tx_bend;

  function automatic logic par_bit(input logic [1:0] m, input logic [7:0] d);
    return (m == mrf_pkg::PAR_ODD) ? ~^d : ^d;
  endfunction : par_bit

  always_comb begin
    par_on = (parity_mode_i != mrf_pkg::PAR_NONE);
    nb_m1 = 4'(mrf_pkg::BITS_BASE - 1) + {3'h0, par_on};
    chr = GW'(CPB) * (GW'(nb_m1) + GW'(1));
    // Least gap rounds up, drop point is the first count past 1.5 characters
    t35 = (chr * GW'(mrf_pkg::GAP_END_HALF) + GW'(1)) >> 1;
    t15 = ((chr * GW'(mrf_pkg::GAP_DROP_HALF)) >> 1) + GW'(1);
    tx_bend = (q.tx_st == mrf_pkg::TX_SEND) && (q.tx_baud == CPB_M1) && (q.tx_cnt == 4'h0);
  end

  // Next state of transmitter, buffer, idle timer and receiver
  always_comb begin
    logic pop;
    logic wr;
    logic [8:0] head;
    logic bad;
    n = q;
    pop = 1'b0;
    wr = s_valid_i && q.rdy;
    head = q.buf_d[q.buf_rp];
    bad = 1'b0;
    n.tx_done = 1'b0;
    n.rx_valid = 1'b0;
    n.done = 1'b0;
    if (q.tx_st == mrf_pkg::TX_IDLE) begin
      if (q.buf_n != 2'h0 && q.idle >= t35) begin
        pop = 1'b1;
        n.tx_st = mrf_pkg::TX_SEND;
        n.de = 1'b1;
        n.tail = mrf_pkg::TAIL_DATA;
        n.tx_addr = head[7:0];
        n.tx_crc = mrf_pkg::crc_step(mrf_pkg::CRC_INIT, head[7:0]);
      end
    end else if (q.tx_baud != CPB_M1) begin
      n.tx_baud = q.tx_baud + CW'(1);
    end else if (q.tx_cnt != 4'h0) begin
      n.tx_baud = '0;
      n.tx_line = q.tx_sh[0];
      n.tx_sh = {1'b1, q.tx_sh[9:1]};
      n.tx_cnt = q.tx_cnt - 4'h1;
    end else if (q.tail == mrf_pkg::TAIL_DATA && !q.last) begin
      // bytes go out in queue order; line holds stop level while starved
      if (q.buf_n != 2'h0) begin
        pop = 1'b1;
        n.tx_crc = mrf_pkg::crc_step(q.tx_crc, head[7:0]);
      end
    end else if (q.tail == mrf_pkg::TAIL_DATA) begin
      n.tail = mrf_pkg::TAIL_LO;
    end else if (q.tail == mrf_pkg::TAIL_LO) begin
      n.tail = mrf_pkg::TAIL_HI;
    end else begin
      n.tx_st = mrf_pkg::TX_IDLE;
      n.de = 1'b0;
      n.tx_line = 1'b1;
      n.tx_done = 1'b1;
    end
    // Load the next character: start bit now, rest shifted out later
    if (pop || n.tail != q.tail) begin
      n.tx_baud = '0;
      n.tx_line = 1'b0;
      n.tx_cnt = nb_m1;
      if (pop) begin
        n.last = head[8];
        n.tx_sh[7:0] = head[7:0];
      end else begin
        n.tx_sh[7:0] = (n.tail == mrf_pkg::TAIL_LO) ? q.tx_crc[7:0] : q.tx_crc[15:8];
      end
      n.tx_sh[9:8] = {1'b1, par_on ? par_bit(parity_mode_i, n.tx_sh[7:0]) : 1'b1};
    end
    // Two-entry buffer; ready drops when full so the source stalls
    if (wr) begin
      n.buf_d[q.buf_wp] = {s_last_i, s_data_i};
      n.buf_wp = ~q.buf_wp;
    end
    if (pop) begin
      n.buf_rp = ~q.buf_rp;
    end
    n.buf_n = q.buf_n + {1'b0, wr} - {1'b0, pop};
    n.rdy = (n.buf_n != 2'h2);
    // Idle timer runs only while nobody drives the line
    if (q.rx_st == mrf_pkg::RX_BUSY || !rx_i || q.de) begin
      n.idle = '0;
    end else if (q.idle < t35) begin
      n.idle = q.idle + GW'(1);
    end
    // Receiver ignores its own echo while driving
    if (q.rx_st == mrf_pkg::RX_IDLE) begin
      if (!q.de && !rx_i) begin
        n.rx_st = mrf_pkg::RX_BUSY;
        n.rx_baud = CPB_HALF;
        n.rx_k = 4'h0;
      end
    end else if (q.rx_baud != CPB_M1) begin
      n.rx_baud = q.rx_baud + CW'(1);
    end else begin
      n.rx_baud = '0;
      n.rx_k = q.rx_k + 4'h1;
      if (q.rx_k == nb_m1) begin
        n.rx_st = mrf_pkg::RX_IDLE;
        bad = !rx_i || (par_on && q.rx_pb != par_bit(parity_mode_i, q.rx_sh));
        n.rx_data = q.rx_sh;
        n.rx_valid = 1'b1;
        n.rx_first = !q.rx_in;
        n.rx_in = 1'b1;
        n.rx_crc = mrf_pkg::crc_step(q.rx_in ? q.rx_crc : mrf_pkg::CRC_INIT, q.rx_sh);
        if (!q.rx_in) begin
          n.rx_addr = q.rx_sh;
          n.rx_fn = 8'h00;
          n.rx_cnt = 4'h1;
          n.perr = bad;
        end else begin
          n.perr = q.perr || bad;
          if (q.rx_cnt == 4'h1) begin
            n.rx_fn = q.rx_sh;
          end
          if (q.rx_cnt != 4'hf) begin
            n.rx_cnt = q.rx_cnt + 4'h1;
          end
        end
      end else if (q.rx_k == 4'h0) begin
        if (rx_i) begin
          n.rx_st = mrf_pkg::RX_IDLE; // Glitch, not a start bit
        end
      end else if (q.rx_k <= 4'(mrf_pkg::DATA_BITS)) begin
        n.rx_sh = {rx_i, q.rx_sh[7:1]};
      end else begin
        n.rx_pb = rx_i;
      end
    end
    if (q.rx_in && q.rx_st == mrf_pkg::RX_IDLE && q.idle == t15) begin
      n.rx_in = 1'b0;
      n.done = 1'b1;
      n.crc_err = (q.rx_cnt < mrf_pkg::MIN_FRAME) || (q.rx_crc != mrf_pkg::CRC_GOOD);
      n.par_err = q.perr;
      // reply must come from the addressed station
      n.addr_err = (q.rx_addr != q.tx_addr) || (q.rx_addr == mrf_pkg::ADDR_BCAST) ||
                   (q.rx_addr > mrf_pkg::ADDR_MAX);
      n.exc = q.rx_fn[mrf_pkg::FN_ERR_BIT];
      n.ok = !n.crc_err && !n.par_err && !n.addr_err && !n.exc;
    end
  end

  // Single state register, synchronous reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= ST_RST;
    end else begin
      q <= n;
    end
  end

  // Outputs come straight from the state register
  assign s_ready_o = q.rdy;
  assign tx_o = q.tx_line;
  assign de_o = q.de;
  assign rx_data_o = q.rx_data;
  assign rx_valid_o = q.rx_valid;
  assign rx_first_o = q.rx_first;
  assign frame_done_o = q.done;
  assign frame_ok_o = q.ok;
  assign crc_err_o = q.crc_err;
  assign par_err_o = q.par_err;
  assign addr_err_o = q.addr_err;
  assign exc_o = q.exc;
  assign tx_done_o = q.tx_done;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_hi_done;
    q.tail == mrf_pkg::TAIL_HI && tx_bend;
  endsequence
  sequence s_to_lo;
    q.tail == mrf_pkg::TAIL_DATA ##1 q.tail == mrf_pkg::TAIL_LO;
  endsequence
  sequence s_to_hi;
    q.tail == mrf_pkg::TAIL_LO ##1 q.tail == mrf_pkg::TAIL_HI;
  endsequence

  a_gap_before_start: assert property ($rose(q.de) |-> $past(q.idle) >= $past(t35))
    else $error("frame started before line gap");
  a_release_after_tail: assert property (s_hi_done |=> !q.de && q.tx_done ##1 !q.de)
    else $error("driver not released after check word");
  a_crc_init_ones: assert property ($rose(q.de) |->
      q.tx_crc == mrf_pkg::crc_step(mrf_pkg::CRC_INIT, q.tx_addr))
    else $error("check word not seeded with ones");
  a_crc_low_first: assert property (s_to_lo |-> q.tx_sh[7:0] == q.tx_crc[7:0] && !q.tx_line)
    else $error("low check byte not sent first");
  a_crc_high_next: assert property (s_to_hi |-> q.tx_sh[7:0] == q.tx_crc[15:8])
    else $error("high check byte wrong");
  a_even_parity: assert property ($fell(q.tx_line) && q.tx_cnt == nb_m1 && parity_mode_i == mrf_pkg::PAR_EVEN
      |-> q.tx_sh[8] == ^q.tx_sh[7:0])
    else $error("even parity bit wrong");
  a_odd_parity: assert property ($fell(q.tx_line) && q.tx_cnt == nb_m1 && parity_mode_i == mrf_pkg::PAR_ODD
      |-> q.tx_sh[8] == ~^q.tx_sh[7:0])
    else $error("odd parity bit wrong");
  a_drop_partial: assert property (q.rx_in && q.rx_st == mrf_pkg::RX_IDLE && q.idle == t15
      |=> q.done && !q.rx_in)
    else $error("frame not closed at gap");
  a_bad_check: assert property (q.done && q.rx_crc != mrf_pkg::CRC_GOOD |-> !q.ok && q.crc_err)
    else $error("bad check word accepted");
  a_wrong_station: assert property (q.done && q.rx_addr != q.tx_addr |-> !q.ok && q.addr_err)
    else $error("reply from foreign station accepted");
  a_error_reply: assert property (q.done && q.rx_fn[mrf_pkg::FN_ERR_BIT] |-> q.exc && !q.ok)
    else $error("error reply not flagged");
  a_first_is_addr: assert property (q.rx_valid && q.rx_first |-> q.rx_addr == q.rx_data)
    else $error("first byte not taken as station");
endmodule : mrf_master
`default_nettype wire

// ### mrf_slave.sv
// Behavioural slave station facing the master framer
`timescale 1ns/1ps
`default_nettype none
module mrf_slave #(
  parameter int CPB = 16,
  parameter logic [7:0] STN = 8'h01
) (
  input wire logic clk_i,
  input wire logic tx_i,
  input wire logic de_i,
  input wire logic [1:0] pm_i,
  input wire logic [1:0] fault_i, // 1 parity, 2 station, 3 gap
  output logic rx_o
);
  logic [7:0] got[$];
  logic [7:0] last[$];
  logic [7:0] sent[$];
  logic bad;
  logic last_bad;
  int idle;

  task automatic w(input int n);
    repeat (n) @(posedge clk_i);
  endtask : w

  function automatic int chr();
    return CPB * ((pm_i != 2'h0) ? 11 : 10);
  endfunction : chr

  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      for (int k = 0; k < 8; k++) begin
        c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
      end
    end
    return c;
  endfunction : crc16

  function automatic logic par(input logic [7:0] d);
    return (pm_i == 2'h2) ? ~^d : ^d;
  endfunction : par

  task automatic rd();
    logic [7:0] b;
    w(CPB / 2);
    for (int i = 0; i < 8; i++) begin
      w(CPB);
      b[i] = tx_i;
    end
    if (pm_i != 2'h0) begin
      w(CPB);
      bad |= (tx_i !== par(b));
    end
    w(CPB);
    bad |= (tx_i !== 1'b1);
    got.push_back(b);
  endtask : rd

  // One character out, parity flipped on demand
  task automatic wr(input logic [7:0] d, input logic flip);
    rx_o <= 1'b0;
    w(CPB);
    for (int i = 0; i < 8; i++) begin
      rx_o <= d[i];
      w(CPB);
    end
    if (pm_i != 2'h0) begin
      rx_o <= par(d) ^ flip;
      w(CPB);
    end
    rx_o <= 1'b1;
    w(CPB);
  endtask : wr

  task automatic serve();
    logic [7:0] r[$];
    logic [15:0] c;
    last = got;
    got.delete();
    last_bad = bad;
    bad = 1'b0;
    if (last[0] !== STN) return;
    if (crc16(last) != 16'h0000 || last_bad || !(last[1] inside {8'h03, 8'h06})) r = '{STN, last[1] | 8'h80, 8'h01};
    else if (last[1] == 8'h03) r = '{STN, 8'h03, 8'h02, 8'h13, 8'h88};
    else r = last[0:5];
    if (fault_i == 2'h2) r[0] = STN + 8'h01;
    c = crc16(r);
    r.push_back(c[7:0]);
    r.push_back(c[15:8]);
    sent = r;
    w(7 * chr() / 2);
    foreach (r[i]) begin
      if (fault_i == 2'h3 && i == 2) w(2 * chr());
      wr(r[i], fault_i == 2'h1 && i == 1);
    end
  endtask : serve

  // Line stays high when idle; a short hush closes a frame
  initial begin
    rx_o = 1'b1;
    bad = 1'b0;
    idle = 0;
    forever begin
      @(posedge clk_i);
      if (de_i === 1'b1 && tx_i === 1'b0) begin
        rd();
        idle = 0;
      end else if (++idle > 3 * chr() / 2 && got.size() > 0) begin
        serve();
        idle = 0;
      end
    end
  end
endmodule : mrf_slave
`default_nettype wire

// ### testbench.sv
// Self-checking bench of the master framer against a slave model
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int CPB = 16;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [1:0] pm = 2'h0;
  logic [7:0] s_data = 8'h00;
  logic s_last = 1'b0;
  logic s_valid = 1'b0;
  logic [1:0] fault = 2'h0;
  logic ready, tx, de, rx, done, ok, crc_e, par_e, addr_e, exc;
  logic [7:0] rx_data;
  logic rx_valid, rx_first, tx_done;
  logic [7:0] seen[$];
  logic in_frame = 1'b0;
  int tx_frames = 0;
  int num_errors = 0;
  int total_checks = 0;
  int cycles = 0;

  // Clock of 4 ns
  always #2 clk_i = ~clk_i;

  mrf_master #(.CPB(CPB)) uut (.clk_i(clk_i), .rst_i(rst_i), .parity_mode_i(pm),
    .s_data_i(s_data), .s_last_i(s_last), .s_valid_i(s_valid), .s_ready_o(ready),
    .tx_o(tx), .de_o(de), .rx_i(rx), .rx_data_o(rx_data), .rx_valid_o(rx_valid), .rx_first_o(rx_first),
    .frame_done_o(done), .frame_ok_o(ok), .crc_err_o(crc_e), .par_err_o(par_e),
    .addr_err_o(addr_e), .exc_o(exc), .tx_done_o(tx_done));

  mrf_slave #(.CPB(CPB)) pm0 (.clk_i(clk_i), .tx_i(tx), .de_i(de), .pm_i(pm), .fault_i(fault), .rx_o(rx));

  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    total_checks++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_of_test

  // Strobes watched on every rising edge; a closed frame makes the next byte a station byte
  always @(posedge clk_i) begin
    if (done === 1'b1) begin
      in_frame = 1'b0;
    end
    if (rx_valid === 1'b1) begin
      chk("first", {15'h0, rx_first}, {15'h0, !in_frame});
      seen.push_back(rx_data);
      in_frame = 1'b1;
    end
    if (tx_done === 1'b1) begin
      chk("release", {15'h0, de}, 16'h0);
      tx_frames++;
    end
  end

  // One request out, then the reply verdict; e is reply, ok, crc, par, addr, exc
  task automatic run(input logic [7:0] a, input logic [7:0] f, input logic [1:0] flt, input logic [5:0] e);
    logic [7:0] q[$];
    logic [15:0] c;
    int t;
    int ch;
    int sb;
    int fb;
    int nexp;
    q = '{a, f, 8'($urandom), 8'($urandom), 8'($urandom), 8'($urandom)};
    sb = seen.size();
    fb = tx_frames;
    fault <= flt;
    foreach (q[i]) begin
      s_data <= q[i];
      s_last <= (i == 5);
      s_valid <= 1'b1;
      do @(posedge clk_i); while (ready !== 1'b1);
    end
    s_valid <= 1'b0;
    ch = CPB * ((pm != 2'h0) ? 11 : 10);
    c = pm0.crc16(q);
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    t = 0;
    while (done !== 1'b1 && t < (e[5] ? 30 : 12) * ch) begin
      @(posedge clk_i);
      t++;
    end
    chk("reply", {15'h0, done}, {15'h0, e[5]});
    chk("length", 16'(pm0.last.size()), 16'h8);
    foreach (q[i]) chk("byte", {8'h0, pm0.last[i]}, {8'h0, q[i]});
    chk("parity", {15'h0, pm0.last_bad}, 16'h0);
    if (e[5]) chk("verdict", {11'h0, ok, crc_e, par_e, addr_e, exc}, {11'h0, e[4:0]});
    // A cut reply closes after its first two bytes
    nexp = !e[5] ? 0 : (flt == 2'h3) ? 2 : pm0.sent.size();
    chk("tx frames", 16'(tx_frames - fb), 16'h1);
    chk("rx count", 16'(seen.size() - sb), 16'(nexp));
    for (int i = sb; i < seen.size(); i++) chk("rx byte", {8'h0, seen[i]}, {8'h0, pm0.sent[i - sb]});
    repeat (9 * ch) @(posedge clk_i);
  endtask : run

  // Cut a hung run short
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      num_errors++;
      end_of_test();
    end
  end

  // Seeded random requests with hand-picked faults
  initial begin
    void'($urandom(87));
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int m = 0; m < 3; m++) begin
      pm <= 2'(m);
      run(8'h01, (m == 1) ? 8'h03 : 8'h06, 2'h0, 6'h30);
    end
    pm <= 2'h1;
    run(8'h01, 8'h08, 2'h0, 6'h21);
    run(8'h01, 8'h03, 2'h1, 6'h24);
    run(8'h01, 8'h06, 2'h2, 6'h22);
    run(8'h01, 8'h03, 2'h3, 6'h28);
    run(8'h00, 8'h06, 2'h0, 6'h00);
    run(8'hf7, 8'h03, 2'h0, 6'h00);
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
